//--- common/efp_pkg.sv
// shared constants and types of the earth fault pickup block
package efp_pkg;

  // ------------------------------------------------------------
  // clock and time bases
  // ------------------------------------------------------------
  localparam int unsigned CLK_KHZ     = 40000;
  localparam int unsigned CYCLE_MS    = 5;
  localparam int unsigned STAMP_MS    = 1;
  localparam int unsigned BLK_LEAD_MS = 5;
  localparam int unsigned CYCLE_CLKS  = CYCLE_MS * CLK_KHZ;
  localparam int unsigned STAMP_CLKS  = STAMP_MS * CLK_KHZ;
  localparam logic [5:0]  DIV_LAST    = 6'h1F;

  // ------------------------------------------------------------
  // release ratio in percent of the threshold
  // ------------------------------------------------------------
  localparam logic [6:0] REL_PCT  = 7'h61;
  localparam logic [6:0] FULL_PCT = 7'h64;

  // ------------------------------------------------------------
  // register offsets and fields
  // ------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_THR    = 8'h04;
  localparam logic [7:0] REG_HARM   = 8'h08;
  localparam logic [7:0] REG_OPDLY  = 8'h0C;
  localparam logic [7:0] REG_RELDLY = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_RATIO  = 8'h18;
  localparam logic [7:0] REG_ANGLE  = 8'h1C;
  localparam logic [7:0] REG_EXPECT = 8'h20;
  localparam logic [7:0] REG_REMAIN = 8'h24;
  localparam logic [7:0] REG_STAMP  = 8'h28;
  localparam int CTL_INRUSH   = 0;
  localparam int CTL_FORCE_EN = 1;
  localparam int CTL_FORCE_BK = 2;
  localparam int CTL_INVERSE  = 3;
  localparam int CTL_SEL_LSB  = 4;
  localparam int CTL_MODE_LSB = 8;
  localparam int ST_MODE_LSB  = 4;
  localparam int ST_FAULT_LSB = 8;
  localparam int ST_PICKUP    = 12;

  // ------------------------------------------------------------
  // reset values, selections and modes
  // ------------------------------------------------------------
  localparam logic [19:0] THR_RST    = 20'h02EE0;
  localparam logic [15:0] HARM_RST   = 16'h0001;
  localparam logic [15:0] OPDLY_RST  = 16'h0014;
  localparam logic [15:0] RELDLY_RST = 16'h0000;
  localparam logic [1:0]  SEL_COARSE = 2'h1;
  localparam logic [1:0]  SEL_SENS   = 2'h2;
  localparam logic [1:0]  SEL_CALC   = 2'h3;
  localparam logic [2:0]  MODE_ON    = 3'h1;
  localparam logic [2:0]  MODE_BLK   = 3'h2;
  localparam logic [2:0]  MODE_TEST  = 3'h3;
  localparam logic [2:0]  MODE_TBLK  = 3'h4;
  localparam logic [2:0]  MODE_OFF   = 3'h5;

  typedef enum logic [1:0] {
    COND_NORMAL  = 2'b00,
    COND_START   = 2'b01,
    COND_TRIP    = 2'b10,
    COND_BLOCKED = 2'b11
  } efp_cond_e;

endpackage : efp_pkg

//--- verilog/efp_tick.sv
// periodic one-cycle tick generator
`timescale 1ns/100ps
module efp_tick #(
  parameter int unsigned PERIOD = 2
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic reset,
  // tick
  output logic      tick
);

  logic [31:0] cnt_r;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cnt_r <= 32'h0;
      tick  <= 1'b0;
    end else if (cnt_r == 32'(PERIOD - 1)) begin
      cnt_r <= 32'h0;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h1;
      tick  <= 1'b0;
    end
  end

endmodule : efp_tick

//--- verilog/efp_div.sv
// sequential restoring divider, 32 bits, one quotient bit per clock
`timescale 1ns/100ps
module efp_div (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // request
  input  wire logic        go,
  input  wire logic [31:0] num,
  input  wire logic [31:0] den,
  // answer
  output logic             done,
  output logic [31:0]      quot
);

  logic [31:0] rem_r;
  logic [31:0] q_r;
  logic [5:0]  cnt_r;
  logic        busy_r;
  logic [32:0] sh;
  logic [32:0] diff;
  logic        ge;

  assign sh   = {rem_r, q_r[31]};
  assign diff = sh - {1'b0, den};
  assign ge   = (sh >= {1'b0, den});

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rem_r  <= 32'h0;
      q_r    <= 32'h0;
      cnt_r  <= 6'h0;
      busy_r <= 1'b0;
      done   <= 1'b0;
      quot   <= 32'h0;
    end else begin
      done <= 1'b0;
      if (go && !busy_r) begin
        rem_r  <= 32'h0;
        q_r    <= num;
        cnt_r  <= 6'h0;
        busy_r <= 1'b1;
      end else if (busy_r) begin
        q_r   <= {q_r[30:0], ge};
        rem_r <= ge ? diff[31:0] : sh[31:0];
        cnt_r <= cnt_r + 6'h1;
        if (cnt_r == efp_pkg::DIV_LAST) begin
          busy_r <= 1'b0;
          done   <= 1'b1;
          // a zero divisor saturates instead of faulting
          quot   <= (den == 32'h0) ? 32'hFFFFFFFF : {q_r[30:0], ge};
        end
      end
    end
  end

endmodule : efp_div

//--- verilog/efp_pickup_block.sv
// pick-up, blocking and status logic of one residual overcurrent stage
`timescale 1ns/100ps
module efp_pickup_block #(
  parameter int unsigned CYCLE_CLKS = efp_pkg::CYCLE_CLKS,
  parameter int unsigned STAMP_CLKS = efp_pkg::STAMP_CLKS
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // measurements
  input  wire logic [19:0] coarse_residual_input,
  input  wire logic [19:0] sensitive_residual_input,
  input  wire logic [19:0] computed_residual_input,
  input  wire logic [15:0] harm2_pct,
  input  wire logic [15:0] angle_vs_volt,
  input  wire logic [15:0] angle_vs_curr,
  input  wire logic        volt_present,
  input  wire logic [1:0]  fault_phase,
  input  wire logic        fault_fwd,
  // blocking matrix
  input  wire logic        block_in,
  // stage outputs
  output logic             stage_start,
  output logic             stage_trip,
  output logic             stage_blocked,
  // events
  output logic             evt_valid,
  output logic      [1:0]  evt_kind,
  output logic      [31:0] evt_stamp,
  output logic      [19:0] evt_current,
  output logic      [2:0]  evt_fault,
  output logic             hmi_notify
);

  // ------------------------------------------------------------
  // decoding helpers
  // ------------------------------------------------------------
  function automatic logic [2:0] efp_fault_code(input logic [1:0] ph, input logic fwd);
    logic [2:0] c;
    c = 3'h0;
    case ({ph, fwd})
      3'b010:  c = 3'h1;
      3'b101:  c = 3'h2;
      3'b110:  c = 3'h3;
      3'b011:  c = 3'h4;
      3'b100:  c = 3'h5;
      3'b111:  c = 3'h6;
      default: c = 3'h0;
    endcase
    return c;
  endfunction : efp_fault_code

  function automatic logic [2:0] efp_mode(input logic [2:0] m);
    return (m >= efp_pkg::MODE_ON && m <= efp_pkg::MODE_OFF) ? m : efp_pkg::MODE_ON;
  endfunction : efp_mode

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic [10:0]              ctrl_r;
  logic [19:0]              thr_r;
  logic [15:0]              harm_lim_r;
  logic [15:0]              opdly_r;
  logic [15:0]              reldly_r;
  logic                     cyc_tick;
  logic                     ms_tick;
  logic                     eval;
  logic [31:0]              ms_r;
  logic [19:0]              sel_meas;
  logic [19:0]              meas_r;
  logic                     blk_smp_r;
  logic                     blk_now;
  logic                     inrush;
  logic [2:0]               mode;
  logic                     above;
  logic                     below;
  logic                     pickup_r;
  logic                     pickup_nxt;
  efp_pkg::efp_cond_e       cond_r;
  efp_pkg::efp_cond_e       cond_nxt;
  logic [15:0]              op_cnt_r;
  logic [15:0]              rel_cnt_r;
  logic [15:0]              expected_r;
  logic [15:0]              remain_r;
  logic [19:0]              onset_r;
  logic [2:0]               fault_r;
  logic [15:0]              angle_r;
  logic [19:0]              ratio_r;
  logic                     rdiv_done;
  logic [31:0]              rdiv_q;
  logic                     tdiv_done;
  logic [31:0]              tdiv_q;

  // ------------------------------------------------------------
  // time bases
  // ------------------------------------------------------------
  efp_tick #(.PERIOD(CYCLE_CLKS)) u_cycle (
    .sys_clk (sys_clk),
    .reset   (reset),
    .tick    (cyc_tick)
  );

  efp_tick #(.PERIOD(STAMP_CLKS)) u_stamp (
    .sys_clk (sys_clk),
    .reset   (reset),
    .tick    (ms_tick)
  );

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ms_r <= 32'h0;
    end else if (ms_tick) begin
      ms_r <= ms_r + 32'h1;
    end
  end

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrl_r     <= {efp_pkg::MODE_ON, 2'h0, efp_pkg::SEL_COARSE, 4'h0};
      thr_r      <= efp_pkg::THR_RST;
      harm_lim_r <= efp_pkg::HARM_RST;
      opdly_r    <= efp_pkg::OPDLY_RST;
      reldly_r   <= efp_pkg::RELDLY_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        efp_pkg::REG_CTRL:   ctrl_r     <= reg_wdata[10:0];
        efp_pkg::REG_THR:    thr_r      <= reg_wdata[19:0];
        efp_pkg::REG_HARM:   harm_lim_r <= reg_wdata[15:0];
        efp_pkg::REG_OPDLY:  opdly_r    <= reg_wdata[15:0];
        efp_pkg::REG_RELDLY: reldly_r   <= reg_wdata[15:0];
        default: ;
      endcase
    end
  end

  assign mode = efp_mode(ctrl_r[efp_pkg::CTL_MODE_LSB +: 3]);

  // ------------------------------------------------------------
  // input selection and block sampling at cycle start
  // ------------------------------------------------------------
  always_comb begin
    case (ctrl_r[efp_pkg::CTL_SEL_LSB +: 2])
      efp_pkg::SEL_SENS: sel_meas = sensitive_residual_input;
      efp_pkg::SEL_CALC: sel_meas = computed_residual_input;
      default:           sel_meas = coarse_residual_input;
    endcase
  end

  assign inrush = ctrl_r[efp_pkg::CTL_INRUSH] && (harm2_pct > harm_lim_r);

  // a late external block only counts from the next cycle start
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      blk_smp_r <= 1'b0;
      meas_r    <= 20'h0;
      eval      <= 1'b0;
    end else begin
      eval <= cyc_tick;
      if (cyc_tick) begin
        meas_r    <= sel_meas;
        blk_smp_r <= (ctrl_r[efp_pkg::CTL_FORCE_EN] ? ctrl_r[efp_pkg::CTL_FORCE_BK]
                                                    : block_in)
                     || inrush
                     || mode == efp_pkg::MODE_BLK || mode == efp_pkg::MODE_TBLK;
      end
    end
  end

  assign blk_now = blk_smp_r;

  // ------------------------------------------------------------
  // threshold comparator with fixed release ratio
  // ------------------------------------------------------------
  assign above = (meas_r > thr_r);
  assign below = (27'(meas_r) * 27'(efp_pkg::FULL_PCT))
               < (27'(thr_r) * 27'(efp_pkg::REL_PCT));

  always_comb begin
    pickup_nxt = pickup_r;
    if (above) begin
      pickup_nxt = 1'b1;
    end else if (below) begin
      pickup_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pickup_r <= 1'b0;
    end else if (eval) begin
      pickup_r <= pickup_nxt;
    end
  end

  // ------------------------------------------------------------
  // condition state machine
  // ------------------------------------------------------------
  always_comb begin
    cond_nxt = cond_r;
    case (cond_r)
      efp_pkg::COND_NORMAL: begin
        if (pickup_nxt) begin
          cond_nxt = blk_now ? efp_pkg::COND_BLOCKED : efp_pkg::COND_START;
        end
      end
      efp_pkg::COND_START: begin
        if (blk_now) begin
          cond_nxt = efp_pkg::COND_BLOCKED;
        end else if (!pickup_nxt) begin
          cond_nxt = efp_pkg::COND_NORMAL;
        end else if (op_cnt_r + 16'h1 >= expected_r) begin
          cond_nxt = efp_pkg::COND_TRIP;
        end
      end
      efp_pkg::COND_TRIP: begin
        if (!pickup_nxt) begin
          cond_nxt = efp_pkg::COND_NORMAL;
        end else if (blk_now) begin
          cond_nxt = efp_pkg::COND_BLOCKED;
        end
      end
      efp_pkg::COND_BLOCKED: begin
        if (!pickup_nxt) begin
          cond_nxt = efp_pkg::COND_NORMAL;
        end else if (!blk_now) begin
          cond_nxt = efp_pkg::COND_START;
        end
      end
      default: cond_nxt = efp_pkg::COND_NORMAL;
    endcase
    if (mode == efp_pkg::MODE_OFF) begin
      cond_nxt = efp_pkg::COND_NORMAL;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cond_r        <= efp_pkg::COND_NORMAL;
      stage_start   <= 1'b0;
      stage_trip    <= 1'b0;
      stage_blocked <= 1'b0;
    end else if (eval) begin
      cond_r        <= cond_nxt;
      stage_start   <= (cond_nxt == efp_pkg::COND_START);
      stage_trip    <= (cond_nxt == efp_pkg::COND_TRIP);
      stage_blocked <= (cond_nxt == efp_pkg::COND_BLOCKED);
    end
  end

  // ------------------------------------------------------------
  // operate and release timing, in program cycles
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      op_cnt_r  <= 16'h0;
      rel_cnt_r <= 16'h0;
    end else if (eval) begin
      if (cond_nxt == efp_pkg::COND_START) begin
        op_cnt_r  <= op_cnt_r + 16'h1;
        rel_cnt_r <= 16'h0;
      end else if (cond_nxt == efp_pkg::COND_TRIP) begin
        rel_cnt_r <= 16'h0;
      end else if (cond_r == efp_pkg::COND_TRIP) begin
        op_cnt_r  <= 16'h0;
      end else if (op_cnt_r != 16'h0) begin
        // blocked or released: the partial delay decays like a release
        if (rel_cnt_r + 16'h1 >= reldly_r) begin
          op_cnt_r  <= 16'h0;
          rel_cnt_r <= 16'h0;
        end else begin
          rel_cnt_r <= rel_cnt_r + 16'h1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      remain_r <= 16'h0;
    end else if (cond_r == efp_pkg::COND_START && expected_r > op_cnt_r) begin
      remain_r <= expected_r - op_cnt_r;
    end else begin
      remain_r <= 16'h0;
    end
  end

  // ------------------------------------------------------------
  // ratio and inverse time, both ready well before the next cycle
  // ------------------------------------------------------------
  efp_div u_ratio (
    .sys_clk (sys_clk),
    .reset   (reset),
    .go      (cyc_tick),
    .num     (32'(sel_meas) * 32'(efp_pkg::FULL_PCT)),
    .den     (32'(thr_r)),
    .done    (rdiv_done),
    .quot    (rdiv_q)
  );

  // inverse delay scales as setting times 100 over (ratio - 100)
  efp_div u_time (
    .sys_clk (sys_clk),
    .reset   (reset),
    .go      (rdiv_done),
    .num     (32'(opdly_r) * 32'(efp_pkg::FULL_PCT)),
    .den     ((rdiv_q > 32'(efp_pkg::FULL_PCT)) ? rdiv_q - 32'(efp_pkg::FULL_PCT) : 32'h0),
    .done    (tdiv_done),
    .quot    (tdiv_q)
  );

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ratio_r <= 20'h0;
    end else if (rdiv_done) begin
      ratio_r <= (rdiv_q > 32'h000FFFFF) ? 20'hFFFFF : rdiv_q[19:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      expected_r <= efp_pkg::OPDLY_RST;
    end else if (!ctrl_r[efp_pkg::CTL_INVERSE]) begin
      expected_r <= opdly_r;
    end else if (tdiv_done) begin
      expected_r <= (tdiv_q > 32'h0000FFFF) ? 16'hFFFF : tdiv_q[15:0];
    end
  end

  // ------------------------------------------------------------
  // fault type, angle and events
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fault_r <= 3'h0;
      onset_r <= 20'h0;
      angle_r <= 16'h0;
    end else if (eval) begin
      angle_r <= volt_present ? angle_vs_volt : angle_vs_curr;
      if (cond_r == efp_pkg::COND_NORMAL && cond_nxt != efp_pkg::COND_NORMAL) begin
        fault_r <= efp_fault_code(fault_phase, fault_fwd);
        onset_r <= meas_r;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      evt_valid   <= 1'b0;
      evt_kind    <= 2'h0;
      evt_stamp   <= 32'h0;
      evt_current <= 20'h0;
      evt_fault   <= 3'h0;
      hmi_notify  <= 1'b0;
    end else begin
      evt_valid  <= 1'b0;
      hmi_notify <= 1'b0;
      if (eval && cond_nxt != cond_r && cond_nxt != efp_pkg::COND_NORMAL) begin
        evt_valid   <= 1'b1;
        evt_kind    <= cond_nxt;
        evt_stamp   <= ms_r;
        evt_current <= (cond_r == efp_pkg::COND_NORMAL) ? meas_r : onset_r;
        evt_fault   <= (cond_r == efp_pkg::COND_NORMAL) ? efp_fault_code(fault_phase, fault_fwd)
                                                        : fault_r;
        hmi_notify  <= (cond_nxt == efp_pkg::COND_BLOCKED);
      end
    end
  end

  // ------------------------------------------------------------
  // register reads, unmapped addresses read zero
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= 32'h0;
      if (reg_rd) begin
        case (reg_addr)
          efp_pkg::REG_CTRL:   reg_rdata <= 32'(ctrl_r);
          efp_pkg::REG_THR:    reg_rdata <= 32'(thr_r);
          efp_pkg::REG_HARM:   reg_rdata <= 32'(harm_lim_r);
          efp_pkg::REG_OPDLY:  reg_rdata <= 32'(opdly_r);
          efp_pkg::REG_RELDLY: reg_rdata <= 32'(reldly_r);
          efp_pkg::REG_STATUS: reg_rdata <= 32'({pickup_r, 1'b0, fault_r, 1'b0,
                                                 mode, 2'h0, cond_r});
          efp_pkg::REG_RATIO:  reg_rdata <= 32'(ratio_r);
          efp_pkg::REG_ANGLE:  reg_rdata <= {{16{angle_r[15]}}, angle_r};
          efp_pkg::REG_EXPECT: reg_rdata <= 32'(expected_r);
          efp_pkg::REG_REMAIN: reg_rdata <= 32'(remain_r);
          efp_pkg::REG_STAMP:  reg_rdata <= ms_r;
          default:             reg_rdata <= 32'h0;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_pickup_rise: assert property (eval && above |=> pickup_r)
    else $error("pickup did not set above threshold");
  a_release_hold: assert property (eval && pickup_r && !below |=> pickup_r)
    else $error("pickup released above release level");
  a_cycle_once: assert property (cyc_tick |=> eval ##1 !eval [*8])
    else $error("evaluation not once per program cycle");
  a_start_noblk: assert property (eval |=> (!stage_start || !$past(blk_now)))
    else $error("start asserted while blocked");
  a_block_drops: assert property (eval && cond_r == efp_pkg::COND_START && blk_now
                                  |=> !stage_start && stage_blocked)
    else $error("start not dropped on blocking");
  a_no_timing: assert property (eval && cond_nxt == efp_pkg::COND_BLOCKED
                                |=> op_cnt_r <= $past(op_cnt_r))
    else $error("trip timing advanced while blocked");
  a_block_event: assert property ($rose(stage_blocked) |-> hmi_notify && evt_valid
                                  && evt_kind == efp_pkg::COND_BLOCKED)
    else $error("blocking event missing");
  a_forced_block: assert property (cyc_tick && ctrl_r[efp_pkg::CTL_FORCE_EN]
                                   && ctrl_r[efp_pkg::CTL_FORCE_BK] |=> blk_smp_r)
    else $error("forced blocking not taken");
  a_inrush_block: assert property (cyc_tick && inrush |=> blk_smp_r)
    else $error("inrush blocking not taken");

endmodule : efp_pickup_block

//--- dv/efp_front.sv
// partner model: blocking matrix and residual measurement front end
`timescale 1ns/100ps
module efp_front (
  // clock
  input  wire logic        sys_clk,
  // bench commands
  input  wire logic [19:0] want_mag,
  input  wire logic [19:0] noise,
  input  wire logic [1:0]  ch,
  input  wire logic        want_blk,
  // toward the block
  output logic      [19:0] coarse,
  output logic      [19:0] sens,
  output logic      [19:0] calc,
  output logic             blk
);
  // ------------------------------
  // unselected channels carry noise
  // ------------------------------
  always_ff @(posedge sys_clk) begin
    coarse <= (ch == 2'h1) ? want_mag : noise;
    sens   <= (ch == 2'h2) ? want_mag : noise;
    calc   <= (ch == 2'h3) ? want_mag : noise;
    blk    <= want_blk;
  end
endmodule : efp_front

//--- dv/tb_efp_pickup_block.sv
// self-checking bench of the earth fault pickup block
`timescale 1ns/100ps
module tb_efp_pickup_block;
  // ------------------------------
  // signals
  // ------------------------------
  localparam int CYC = 100;
  localparam int REL = int'(efp_pkg::THR_RST) * 97 / 100;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        rd_d = 1'b0;
  logic        blk_w = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [19:0] mag = 20'h0;
  logic [1:0]  ch = 2'h1;
  logic [15:0] harm = 16'h0;
  logic [19:0] noise = 20'h0;
  logic [15:0] ang = 16'h0;
  logic [31:0] reg_rdata;
  logic [19:0] co, se, ca;
  logic        blk, st, tr, bk, ev, hmi;
  logic [1:0]  ek;
  logic [2:0]  ef;
  logic [31:0] q_rd[$];
  logic [1:0]  q_ev[$];
  integer      seed = 32'h64C0;
  int          errors = 0;
  int          num_checks = 0;

  efp_pickup_block #(.CYCLE_CLKS(CYC), .STAMP_CLKS(4)) DUT (
    .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .coarse_residual_input(co), .sensitive_residual_input(se),
    .computed_residual_input(ca), .harm2_pct(harm), .angle_vs_volt(ang),
    .angle_vs_curr(~ang), .volt_present(ang[0]), .fault_phase(ang[2:1]),
    .fault_fwd(ang[3]), .block_in(blk), .stage_start(st), .stage_trip(tr),
    .stage_blocked(bk), .evt_valid(ev), .evt_kind(ek), .evt_stamp(),
    .evt_current(), .evt_fault(ef), .hmi_notify(hmi));
  efp_front FE (.sys_clk(sys_clk), .want_mag(mag), .noise(noise), .ch(ch),
    .want_blk(blk_w), .coarse(co), .sens(se), .calc(ca), .blk(blk));

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ------------------------------
  // tasks
  // ------------------------------
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : cmp

  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    if (!w) q_rd.push_back(d);
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask : acc

  // drive magnitude and block, note event, wait for stage levels
  task automatic go(input logic [19:0] v, input logic b, input logic [2:0] w,
                    input logic [1:0] k);
    int i;
    mag <= v;
    blk_w <= b;
    if (k != 2'h0) q_ev.push_back(k);
    for (i = 0; i < 1000 && {bk, tr, st} !== w; i++) @(posedge sys_clk);
    cmp("stage", {29'h0, w}, {29'h0, bk, tr, st});
    if (i == 1000) report_and_stop();
  endtask : go

  function automatic logic [19:0] hi();
    return efp_pkg::THR_RST + 20'h1 + 20'($random(seed) & 32'hFFF);
  endfunction : hi

  // fault code expected from the wired {direction, phase} bits
  function automatic logic [31:0] fcode(input logic [2:0] d);
    case (d)
      3'b001:  return 32'h1;
      3'b110:  return 32'h2;
      3'b011:  return 32'h3;
      3'b101:  return 32'h4;
      3'b010:  return 32'h5;
      3'b111:  return 32'h6;
      default: return 32'h0;
    endcase
  endfunction : fcode

  // ------------------------------
  // result watcher and sequence
  // ------------------------------
  always @(posedge sys_clk) begin
    rd_d <= reg_rd;
    if (rd_d) cmp("rdata", q_rd.pop_front(), reg_rdata);
    if (ev) begin
      cmp("evt_kind", {30'h0, q_ev[0]}, {30'h0, ek});
      cmp("evt_fault", fcode(ang[3:1]), {29'h0, ef});
      cmp("hmi", {31'h0, q_ev[0] == 2'h3}, {31'h0, hmi});
      void'(q_ev.pop_front());
    end
  end

  initial begin
    noise <= 20'($random(seed) & 32'h1FFF);
    ang <= 16'($random(seed));
    harm <= 16'h2 + 16'($random(seed) & 32'hFFF);
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    acc(1'b0, efp_pkg::REG_CTRL, 32'h110);
    acc(1'b0, efp_pkg::REG_THR, 32'h2EE0);
    acc(1'b0, 8'hFC, 32'h0);
    for (int m = 1; m <= 5; m++) begin
      acc(1'b1, efp_pkg::REG_CTRL, 32'h10 | 32'(m << 8));
      acc(1'b0, efp_pkg::REG_STATUS, 32'(m << 4));
    end
    acc(1'b1, efp_pkg::REG_OPDLY, 32'hFFF);
    for (int s = 3; s >= 1; s--) begin
      acc(1'b1, efp_pkg::REG_CTRL, 32'h100 | 32'(s << 4));
      ch <= 2'(s);
      go(hi(), 1'b0, 3'b001, 2'h1);
      go(20'h0, 1'b0, 3'b000, 2'h0);
    end
    go(hi(), 1'b0, 3'b001, 2'h1);
    go(20'(REL), 1'b0, 3'b001, 2'h0);
    repeat (3 * CYC) @(posedge sys_clk);
    go(20'(REL), 1'b0, 3'b001, 2'h0);
    go(20'(REL - 1), 1'b0, 3'b000, 2'h0);
    go(hi(), 1'b0, 3'b001, 2'h1);
    go(hi(), 1'b1, 3'b100, 2'h3);
    go(20'h0, 1'b1, 3'b000, 2'h0);
    go(hi(), 1'b1, 3'b100, 2'h3);
    go(20'h0, 1'b0, 3'b000, 2'h0);
    acc(1'b1, efp_pkg::REG_OPDLY, 32'h2);
    q_ev.push_back(2'h1);
    go(hi(), 1'b0, 3'b010, 2'h2);
    go(20'h0, 1'b0, 3'b000, 2'h0);
    acc(1'b1, efp_pkg::REG_CTRL, 32'h116);
    go(hi(), 1'b0, 3'b100, 2'h3);
    go(20'h0, 1'b0, 3'b000, 2'h0);
    // inverse mode at three times the threshold: 2 * 100 / (300 - 100)
    acc(1'b1, efp_pkg::REG_CTRL, 32'h118);
    q_ev.push_back(2'h1);
    go(20'(3 * int'(efp_pkg::THR_RST)), 1'b0, 3'b010, 2'h2);
    acc(1'b0, efp_pkg::REG_EXPECT, 32'h1);
    go(20'h0, 1'b0, 3'b000, 2'h0);
    acc(1'b1, efp_pkg::REG_CTRL, 32'h111);
    go(hi(), 1'b0, 3'b100, 2'h3);
    go(20'h0, 1'b0, 3'b000, 2'h0);
    cmp("pending", 32'h0, 32'(q_ev.size()));
    report_and_stop();
  end
endmodule : tb_efp_pickup_block
